// >>> rtl/eeprom_write_ctrl.sv
// Purpose: two-wire slave front end: address match, word address, page write
// Assumes: start/stop detected elsewhere and given as core-clock pulses
// Notes:   bus clock and data pins pass two flops before use
`timescale 1ns/1ps
module eeprom_write_ctrl
  import eeprom_wr_pkg::*;
#(
  parameter int unsigned WRITE_CYCLE = WRITE_CYCLE_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  input  wire logic              i_start,
  input  wire logic              i_stop,
  input  wire logic              i_chip_select_hi,
  input  wire logic              i_chip_select_lo,
  input  wire logic              i_write_protect,
  input  wire logic              i_prog_ready,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  output logic                   o_busy,
  output logic                   o_standby,
  output logic                   o_read_req,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [ADDR_W-1:0] o_prog_addr,
  output logic      [DATA_W-1:0] o_prog_data,
  output logic                   o_prog_valid,
  output logic                   o_prog_commit
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] csh_sync_q;
  logic [1:0] csl_sync_q;
  logic [1:0] wp_sync_q;
  logic       scl_prev_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      csh_sync_q <= 2'h0;
      csl_sync_q <= 2'h0;
      wp_sync_q  <= 2'h0;
      scl_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      csh_sync_q <= {csh_sync_q[0], i_chip_select_hi};
      csl_sync_q <= {csl_sync_q[0], i_chip_select_lo};
      wp_sync_q  <= {wp_sync_q[0], i_write_protect};
      scl_prev_q <= scl_sync_q[1];
    end
  end

  wire scl_s   = scl_sync_q[1];
  wire sda_s   = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;

  // ****************************************************************
  // byte receiver
  // ****************************************************************
  phase_t             phase_q;
  phase_t             phase_d;
  logic [7:0]         shift_q;
  logic [3:0]         bitcnt_q;
  logic               ack_slot_q;
  logic               ack_drive_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [ADDR_W-1:0]  addr_d;
  logic [ADDR_W-1:0]  prog_base_q;
  logic               have_data_q;
  logic               protect_q;
  logic [22:0]        wcnt_q;
  logic               commit_q;

  // eighth bit completes a byte; shift in msb first
  wire [7:0] byte_now   = {shift_q[6:0], sda_s};
  wire       byte_done  = scl_rise & ~ack_slot_q & (bitcnt_q == 4'(BITS_PER_BYTE - 1));
  wire       in_frame   = (phase_q != ST_IDLE) & (phase_q != ST_PROGRAM)
                          & (phase_q != ST_IGNORE);

  // pins are hardwired; a floating pin is pulled to zero before it reaches here
  wire       cs_match   = (byte_now[CS_HI_POS] == csh_sync_q[1])
                          & (byte_now[CS_LO_POS] == csl_sync_q[1]);
  wire       type_match = (byte_now[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE);
  wire       dev_match  = type_match & cs_match;
  wire       is_read    = byte_now[RW_POS];

  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    // low byte wraps inside the page, row bits stay put
    page_inc = {a[ADDR_W-1:8], a[7:0] + 8'h01};
  endfunction : page_inc

  // ****************************************************************
  // data path fifo
  // ****************************************************************
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic [DATA_W-1:0] fifo_rd_data;
  wire  data_byte   = byte_done & (phase_q == ST_DATA);
  // a full fifo withholds the acknowledge so the master sees a nack
  wire  data_accept = data_byte & fifo_wr_ready;
  wire  fifo_flush  = i_start & (phase_q != ST_PROGRAM);

  byte_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_flush    (fifo_flush),
    .i_wr_data  (byte_now),
    .i_wr_valid (data_byte),
    .o_wr_ready (fifo_wr_ready),
    .o_rd_data  (fifo_rd_data),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (i_prog_ready)
  );

  // ****************************************************************
  // phase sequencing
  // ****************************************************************
  wire stop_commit = i_stop & (phase_q == ST_DATA) & have_data_q
                     & ~wp_sync_q[1];
  wire prog_done   = (phase_q == ST_PROGRAM) & (wcnt_q == 23'(WRITE_CYCLE - 1));

  always_comb
  begin
    phase_d = phase_q;
    addr_d  = addr_q;
    case (phase_q)
      ST_IDLE,
      ST_IGNORE:
      begin
        if (i_start)
        begin
          phase_d = ST_DEVADDR;
        end
      end
      ST_DEVADDR:
      begin
        if (byte_done)
        begin
          if (!dev_match)
          begin
            phase_d = ST_IGNORE;
          end
          else if (is_read)
          begin
            phase_d = ST_IGNORE;
          end
          else
          begin
            phase_d = ST_WADDR_HI;
            addr_d  = {byte_now[TOP_BIT_POS], addr_q[15:0]};
          end
        end
      end
      ST_WADDR_HI:
      begin
        if (byte_done)
        begin
          phase_d = ST_WADDR_LO;
          addr_d  = {addr_q[16], byte_now, addr_q[7:0]};
        end
      end
      ST_WADDR_LO:
      begin
        if (byte_done)
        begin
          phase_d = ST_DATA;
          addr_d  = {addr_q[16:8], byte_now};
        end
      end
      ST_DATA:
      begin
        if (data_accept)
        begin
          addr_d = page_inc(addr_q);
        end
      end
      ST_PROGRAM:
      begin
        if (prog_done)
        begin
          phase_d = ST_IDLE;
        end
      end
      default:
      begin
        phase_d = ST_IDLE;
      end
    endcase
    // start inside a frame restarts the address phase
    if (i_start && in_frame)
    begin
      phase_d = ST_DEVADDR;
    end
    if (i_stop && phase_q != ST_PROGRAM)
    begin
      phase_d = stop_commit ? ST_PROGRAM : ST_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      phase_q <= ST_IDLE;
      addr_q  <= ADDR_RST;
    end
    else
    begin
      phase_q <= phase_d;
      addr_q  <= addr_d;
    end
  end

  // ****************************************************************
  // bit counter and acknowledge
  // ****************************************************************
  // the ack slot drives low only for bytes that are accepted
  wire ack_want = byte_done & (
                    ((phase_q == ST_DEVADDR) & dev_match)
                  | (phase_q == ST_WADDR_HI) | (phase_q == ST_WADDR_LO)
                  | data_accept);

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      shift_q     <= SHIFT_RST;
      bitcnt_q    <= BITCNT_RST;
      ack_slot_q  <= 1'b0;
      ack_drive_q <= 1'b0;
    end
    else if (i_start || phase_q == ST_PROGRAM || phase_q == ST_IDLE)
    begin
      shift_q     <= SHIFT_RST;
      bitcnt_q    <= BITCNT_RST;
      ack_slot_q  <= 1'b0;
      ack_drive_q <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_slot_q)
      begin
        ack_slot_q <= 1'b0;
      end
      else if (byte_done)
      begin
        shift_q    <= byte_now;
        bitcnt_q   <= BITCNT_RST;
        ack_slot_q <= 1'b1;
        ack_drive_q <= ack_want;
      end
      else
      begin
        shift_q  <= byte_now;
        bitcnt_q <= bitcnt_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // write cycle and programming outputs
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      have_data_q <= 1'b0;
      protect_q   <= 1'b0;
      wcnt_q      <= '0;
      prog_base_q <= ADDR_RST;
      commit_q    <= 1'b0;
    end
    else
    begin
      commit_q <= stop_commit;
      if (i_start && phase_q != ST_PROGRAM)
      begin
        have_data_q <= 1'b0;
      end
      else if (data_accept)
      begin
        have_data_q <= 1'b1;
      end
      if (phase_d == ST_WADDR_LO && phase_q == ST_WADDR_HI)
      begin
        prog_base_q <= addr_d;
      end
      if (stop_commit)
      begin
        protect_q <= wp_sync_q[1];
        wcnt_q    <= '0;
      end
      else if (phase_q == ST_PROGRAM)
      begin
        wcnt_q <= wcnt_q + 23'h1;
      end
    end
  end

  // data stream to the array: one byte per pulse, pointer wraps in page
  logic [ADDR_W-1:0] prog_ptr_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prog_ptr_q   <= ADDR_RST;
      o_prog_addr  <= ADDR_RST;
      o_prog_data  <= SHIFT_RST;
      o_prog_valid <= 1'b0;
    end
    else
    begin
      o_prog_valid <= fifo_rd_valid & i_prog_ready;
      if (phase_q == ST_WADDR_LO && byte_done)
      begin
        prog_ptr_q <= {addr_q[16:8], byte_now};
      end
      else if (fifo_rd_valid && i_prog_ready)
      begin
        o_prog_addr <= prog_ptr_q;
        o_prog_data <= fifo_rd_data;
        prog_ptr_q  <= page_inc(prog_ptr_q);
      end
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_sda_out     <= 1'b0;
      o_sda_oe      <= 1'b0;
      o_busy        <= 1'b0;
      o_standby     <= 1'b1;
      o_read_req    <= 1'b0;
      o_addr        <= ADDR_RST;
      o_prog_commit <= 1'b0;
    end
    else
    begin
      o_sda_out <= 1'b0;
      // drive low from the eighth falling edge until the ninth falls
      if (scl_fall)
      begin
        o_sda_oe <= ack_slot_q & ack_drive_q;
      end
      if (phase_q == ST_PROGRAM || phase_q == ST_IDLE)
      begin
        o_sda_oe <= 1'b0;
      end
      o_busy        <= (phase_d == ST_PROGRAM);
      o_standby     <= (phase_d == ST_IDLE);
      o_read_req    <= byte_done & (phase_q == ST_DEVADDR) & dev_match & is_read;
      o_addr        <= addr_d;
      o_prog_commit <= commit_q & ~protect_q;
    end
  end

endmodule : eeprom_write_ctrl

// >>> rtl/eeprom_wr_pkg.sv
// Purpose: shared constants for the two-wire EEPROM write front end
// Assumes: core clock 25 MHz, bus clock sampled as a plain input
// Notes:   array geometry, address byte layout, write cycle timing
package eeprom_wr_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int unsigned PAGE_COUNT     = 512;
  localparam int unsigned PAGE_BYTES     = 256;
  localparam int unsigned ADDR_W         = 17;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned FIFO_DEPTH     = 8;

  // ****************************************************************
  // address byte layout
  // ****************************************************************
  localparam logic [3:0]  DEV_TYPE_CODE  = 4'hA;
  localparam int unsigned TYPE_MSB       = 7;
  localparam int unsigned TYPE_LSB       = 4;
  localparam int unsigned CS_HI_POS      = 3;
  localparam int unsigned CS_LO_POS      = 2;
  localparam int unsigned TOP_BIT_POS    = 1;
  localparam int unsigned RW_POS         = 0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned WRITE_CYCLE_US = 5000;
  localparam int unsigned WRITE_CYCLE_CYC = (WRITE_CYCLE_US / 1000) * (CLK_HZ / 1000);
  localparam int unsigned BITS_PER_BYTE  = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [16:0] ADDR_RST       = 17'h00000;
  localparam logic [7:0]  SHIFT_RST      = 8'h00;
  localparam logic [3:0]  BITCNT_RST     = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_WADDR_HI,
    ST_WADDR_LO,
    ST_DATA,
    ST_IGNORE,
    ST_PROGRAM
  } phase_t;

endpackage : eeprom_wr_pkg

// >>> rtl/byte_fifo.sv
// Purpose: small valid/ready FIFO for received data bytes
// Assumes: single clock, asynchronous active-low reset
// Notes:   read data come out of a register
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_flush,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic      [WIDTH-1:0] o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wptr_q;
  logic [PW:0]      rptr_q;
  logic [PW:0]      count;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;
  logic             out_take;

  // ****************************************************************
  // flags
  // ****************************************************************
  assign count      = wptr_q - rptr_q;
  assign full       = (count == (PW+1)'(DEPTH));
  assign empty      = (count == '0);
  assign o_wr_ready = ~full;
  assign do_wr      = i_wr_valid & ~full;
  // output register refills whenever it is empty or being taken
  assign out_take   = ~o_rd_valid | i_rd_ready;
  assign do_rd      = ~empty & out_take;

  always_ff @(posedge i_core_clk)
  begin
    if (do_wr)
    begin
      mem_q[wptr_q[PW-1:0]] <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wptr_q     <= '0;
      rptr_q     <= '0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end
    else if (i_flush)
    begin
      wptr_q     <= '0;
      rptr_q     <= '0;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      if (do_wr)
      begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (do_rd)
      begin
        rptr_q    <= rptr_q + 1'b1;
        o_rd_data <= mem_q[rptr_q[PW-1:0]];
      end
      if (out_take)
      begin
        o_rd_valid <= do_rd;
      end
    end
  end

endmodule : byte_fifo

// >>> test/eeprom_wr_chk.sv
// Purpose: port-level assertions for the two-wire EEPROM write front end
// Assumes: one core clock domain, asynchronous active-low reset
// Notes:   write cycle length handed in through the bind
`timescale 1ns/1ps
module eeprom_wr_chk
  import eeprom_wr_pkg::*;
#(
  parameter int unsigned WRITE_CYCLE = WRITE_CYCLE_CYC
) (
  input wire logic              i_core_clk,
  input wire logic              i_arst_n,
  input wire logic              i_stop,
  input wire logic              i_start,
  input wire logic              i_write_protect,
  input wire logic              o_sda_out,
  input wire logic              o_sda_oe,
  input wire logic              o_busy,
  input wire logic              o_standby,
  input wire logic [ADDR_W-1:0] o_prog_addr,
  input wire logic              o_prog_valid,
  input wire logic              o_prog_commit
);
  // ****************************************************************
  // helper state
  // ****************************************************************
  int unsigned       busy_cnt_q;
  logic [ADDR_W-1:0] last_q;
  logic              have_q;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  // busy length counted here, a repetition would be far too long
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      busy_cnt_q <= 0;
      have_q     <= 1'b0;
      last_q     <= '0;
    end
    else
    begin
      busy_cnt_q <= o_busy ? busy_cnt_q + 1 : 0;
      have_q     <= i_start ? 1'b0 : (have_q | o_prog_valid);
      last_q     <= o_prog_valid ? o_prog_addr : last_q;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_SDA_OUT_LOW: assert property (
    o_sda_oe |-> !o_sda_out) else $error("ack drive is not low");
  AST_BUSY_NO_ACK: assert property (
    o_busy |-> !o_sda_oe) else $error("ack driven while programming");
  AST_BUSY_FROM_STOP: assert property (
    $rose(o_busy) |-> $past(i_stop)) else $error("programming without stop");
  AST_BUSY_LEN: assert property (
    $fell(o_busy) |-> (busy_cnt_q >= WRITE_CYCLE - 1) && (busy_cnt_q <= WRITE_CYCLE + 1))
    else $error("programming length wrong");
  AST_STANDBY_AFTER: assert property (
    $fell(o_busy) |-> ##[0:2] o_standby) else $error("no standby after programming");
  AST_BUSY_NOT_STANDBY: assert property (
    o_busy |-> !o_standby) else $error("standby while programming");
  AST_COMMIT_IN_BUSY: assert property (
    o_prog_commit |-> o_busy && $past(o_busy)) else $error("commit outside programming");
  AST_COMMIT_WP: assert property (
    o_prog_commit |-> !$past(i_write_protect, 4)) else $error("commit while protected");
  AST_PAGE_WRAP: assert property (
    o_prog_valid && have_q |-> o_prog_addr == {last_q[ADDR_W-1:8], last_q[7:0] + 8'h01})
    else $error("byte address step wrong");
endmodule : eeprom_wr_chk

// >>> test/bus_master_model.sv
// Purpose: two-wire bus master driving the write front end
// Assumes: bit period of 8 core clocks (320 ns), pull-up on the data line
// Notes:   start and stop also given as one-cycle detector pulses
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_start,
  output logic      o_stop
);
  // ****************************************************************
  // bus actions
  // ****************************************************************
  initial
  begin
    o_scl   = 1'b1;
    o_sda   = 1'b1;
    o_start = 1'b0;
    o_stop  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick

  task automatic frame_start();
    tick(1);
    o_sda   = 1'b0;
    o_start = 1'b1;
    tick(1);
    o_start = 1'b0;
    tick(3);
    o_scl = 1'b0;
  endtask : frame_start

  // data changes only with the clock low, so no false start or stop
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      o_sda = b[i];
      tick(4);
      o_scl = 1'b1;
      tick(4);
      o_scl = 1'b0;
    end
    o_sda = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(3);
    ack = ~i_sda;
    tick(1);
    o_scl = 1'b0;
  endtask : send_byte

  task automatic frame_stop();
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    o_sda  = 1'b1;
    o_stop = 1'b1;
    tick(1);
    o_stop = 1'b0;
    tick(4);
  endtask : frame_stop
endmodule : bus_master_model

// >>> test/tb_top.sv
// Purpose: self-checking bench for the EEPROM write front end
// Assumes: 25 MHz core clock, shortened write cycle
// Notes:   sda line is wired-and of master and device drive
`timescale 1ns/1ps
module tb_top;
  import eeprom_wr_pkg::*;
  localparam int unsigned WC = 200;
  logic              i_core_clk = 1'b0;
  logic              i_arst_n   = 1'b0;
  logic              scl, sda_m, start_p, stop_p, sda_line, ack;
  logic              cs_hi = 1'b0, cs_lo = 1'b0, wp = 1'b0, prog_ready = 1'b1;
  logic              o_sda_out, o_sda_oe, o_busy, o_standby, o_read_req;
  logic              o_prog_valid, o_prog_commit;
  logic [ADDR_W-1:0] o_addr, o_prog_addr;
  logic [DATA_W-1:0] o_prog_data;
  logic [24:0]       prog_q[$];
  int                n_errors = 0, tests_run = 0, n_commit = 0, n_read = 0, cyc = 0, n0;

  always #20 i_core_clk = ~i_core_clk;
  assign sda_line = (o_sda_oe ? o_sda_out : 1'b1) & sda_m;

  bus_master_model u_m (.i_core_clk(i_core_clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda(sda_m), .o_start(start_p), .o_stop(stop_p));

  eeprom_write_ctrl #(.WRITE_CYCLE(WC)) u_dut (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda_line), .i_start(start_p),
    .i_stop(stop_p), .i_chip_select_hi(cs_hi), .i_chip_select_lo(cs_lo),
    .i_write_protect(wp), .i_prog_ready(prog_ready), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_busy(o_busy), .o_standby(o_standby), .o_read_req(o_read_req),
    .o_addr(o_addr), .o_prog_addr(o_prog_addr), .o_prog_data(o_prog_data),
    .o_prog_valid(o_prog_valid), .o_prog_commit(o_prog_commit));

  // ****************************************************************
  // monitor, timeout, compare tasks
  // ****************************************************************
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (o_prog_valid === 1'b1 && prog_ready) prog_q.push_back({o_prog_addr, o_prog_data});
    if (o_prog_commit === 1'b1) n_commit++;
    if (o_read_req === 1'b1) n_read++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s exp %b got %b", name, exp, got);
      n_errors++;
    end
  endtask : chk_bit

  task automatic chk_word(input string name, input logic [24:0] exp, input logic [24:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s exp %h got %h", name, exp, got);
      n_errors++;
    end
  endtask : chk_word

  task automatic put(input logic [7:0] b, input logic exp, input string name);
    u_m.send_byte(b, ack);
    chk_bit(name, exp, ack);
  endtask : put

  task automatic addr_try(input logic [7:0] b, input logic exp, input string name);
    u_m.frame_start();
    put(b, exp, name);
    u_m.frame_stop();
  endtask : addr_try

  // bounded wait, a hung cycle shows as a mismatch
  task automatic wait_idle();
    int k;
    k = 0;
    while (o_busy !== 1'b0 && k < 400)
    begin
      @(posedge i_core_clk);
      k++;
    end
    #1;
    chk_bit("busy end", 1'b0, o_busy);
  endtask : wait_idle

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    #1 i_arst_n = 1'b1;
    u_m.tick(3);
    chk_bit("standby", 1'b1, o_standby);
    chk_bit("busy", 1'b0, o_busy);
    $display("test reset done");
    for (int p = 0; p < 4; p++)
    begin
      cs_hi = p[1];
      cs_lo = p[0];
      u_m.tick(4);
      addr_try({4'hA, p[1], p[0], 2'b00}, 1'b1, "match");
      addr_try({4'hA, ~p[1], p[0], 2'b00}, 1'b0, "hi miss");
      addr_try({4'hA, p[1], ~p[0], 2'b00}, 1'b0, "lo miss");
      addr_try({4'hB, p[1], p[0], 2'b00}, 1'b0, "type miss");
    end
    cs_hi = 1'b1;
    cs_lo = 1'b0;
    u_m.frame_start();
    u_m.send_byte(8'hA9, ack);
    u_m.frame_stop();
    chk_word("read req", 25'h1, 25'(n_read));
    $display("test addressing done");
    // page write crossing the page end on purpose
    n0 = prog_q.size();
    u_m.frame_start();
    put(8'hAA, 1'b1, "dev wr");
    put(8'h12, 1'b1, "addr hi");
    put(8'hFE, 1'b1, "addr lo");
    for (int i = 0; i < 3; i++) put(8'h30 + 8'(i), 1'b1, "data");
    u_m.frame_stop();
    chk_bit("busy", 1'b1, o_busy);
    chk_word("ptr", {8'h00, 17'h11201}, {8'h00, o_addr});
    for (int i = 0; i < 3; i++)
      chk_word("prog", {1'b1, 8'h12, 8'hFE + 8'(i), 8'h30 + 8'(i)}, prog_q[n0 + i]);
    u_m.tick(20);
    wp = 1'b1;
    addr_try(8'hA8, 1'b0, "poll busy");
    wait_idle();
    chk_word("commit", 25'h1, 25'(n_commit));
    chk_bit("standby", 1'b1, o_standby);
    $display("test page write done");
    // protected write
    u_m.frame_start();
    put(8'hA8, 1'b1, "wp dev");
    put(8'h00, 1'b1, "wp hi");
    put(8'h10, 1'b1, "wp lo");
    put(8'h55, 1'b1, "wp data");
    u_m.frame_stop();
    u_m.tick(10);
    chk_bit("wp busy", 1'b0, o_busy);
    chk_bit("wp standby", 1'b1, o_standby);
    chk_word("wp commit", 25'h1, 25'(n_commit));
    wp = 1'b0;
    u_m.tick(4);
    $display("test protect done");
    // full buffer with the array side stalled
    prog_ready = 1'b0;
    n0 = prog_q.size();
    u_m.frame_start();
    put(8'hA8, 1'b1, "fifo dev");
    put(8'h00, 1'b1, "fifo hi");
    put(8'h00, 1'b1, "fifo lo");
    // eight words in the buffer plus one in its output register
    for (int i = 0; i < 10; i++) put(8'(i), i < 9, "fifo data");
    prog_ready = 1'b1;
    u_m.frame_stop();
    wait_idle();
    chk_word("drained", 25'h9, 25'(prog_q.size() - n0));
    chk_word("commit", 25'h2, 25'(n_commit));
    $display("test buffer done");
    wrap_up();
  end
endmodule : tb_top

bind eeprom_write_ctrl eeprom_wr_chk #(.WRITE_CYCLE(WRITE_CYCLE)) u_chk (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_stop(i_stop), .i_start(i_start),
  .i_write_protect(i_write_protect), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_busy(o_busy), .o_standby(o_standby), .o_prog_addr(o_prog_addr),
  .o_prog_valid(o_prog_valid), .o_prog_commit(o_prog_commit));
